// ==== src/pam_core.sv ====
// The implementer's own choices: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
// Notes on behaviour
// - sample on rise, output after fifth edge
// - strap low internal ref, high external
// - config pins pick unity, half or unused
// - both config pins low means power-down
// - low enable drives bus, else released
// - results are unsigned straight binary
// - over-range flag travels with its result
// - output enable acts without the clock
module pam_core
  import pam_pkg::*;
#(
  parameter int LATENCY = pam_pkg::PAM_LATENCY
) (
  input  wire logic                          mclk_i,       // sample clock
  input  wire logic                          arst_n_i,     // async reset
  input  wire logic signed [pam_pkg::PAM_AIN_W-1:0] ain_i, // front-end value
  input  wire logic [11:0]                   ext_span_i,   // ext half span
  input  wire logic                          reference_source_select_i, // strap
  input  wire logic                          config_select_low_i,  // pin
  input  wire logic                          config_select_high_i, // pin
  input  wire logic                          out_en_n_i,   // bus enable, low
  output logic [pam_pkg::PAM_DATA_W-1:0]     sample_data_bus_o,  // data
  output logic [pam_pkg::PAM_DATA_W-1:0]     sample_data_bus_oe_o, // drive
  output logic                               over_range_flag_o,  // ovr
  output logic                               sample_valid_o, // fresh data
  output logic                               mode_fault_o, // unused code
  input  wire logic [pam_pkg::PAM_ADDR_W-1:0] avs_address,  // byte addr
  input  wire logic                          avs_read,     // read
  input  wire logic                          avs_write,    // write
  input  wire logic [31:0]                   avs_writedata, // wdata
  input  wire logic [3:0]                    avs_byteenable, // lanes
  output logic [31:0]                        avs_readdata, // rdata
  output logic                               avs_waitrequest, // stall
  output logic                               irq_o         // interrupt
);
  import pam_pkg::*;

  // ******************************************************
  // pin synchronisers
  // ******************************************************
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= {reference_source_select_i, config_select_high_i,
                   config_select_low_i};
      pin_s2_r <= pin_s1_r;
    end
  end

  // ******************************************************
  // mode decode
  // ******************************************************
  pam_mode_t mode;
  logic      ref_ext;

  always_comb begin
    ref_ext = pin_s2_r[2];
    case (pin_s2_r[1:0])
      PAM_CFG_DOWN:   mode = PAM_MODE_DOWN;
      PAM_CFG_UNITY:  mode = PAM_MODE_UNITY;
      PAM_CFG_HALF:   mode = PAM_MODE_HALF;
      PAM_CFG_UNUSED: mode = PAM_MODE_FAULT;
      default:        mode = PAM_MODE_DOWN;
    endcase
  end

  // the unused code converts nothing: safer than guessing a gain
  logic converting;
  assign converting   = (mode == PAM_MODE_UNITY) || (mode == PAM_MODE_HALF);
  assign mode_fault_o = (mode == PAM_MODE_FAULT);

  // ******************************************************
  // quantiser
  // ******************************************************
  logic signed [PAM_AIN_W-1:0] vp;
  logic signed [27:0]          scaled;
  logic signed [27:0]          span;
  logic [PAM_DATA_W-1:0]       code;
  logic                        over_range_indicator;

  always_comb begin
    vp = (mode == PAM_MODE_HALF) ? (ain_i >>> 1) : ain_i;
    // external span of zero would divide by zero; fall back to internal
    span = (ref_ext && ext_span_i != 12'h000) ?
           28'(ext_span_i) : 28'(PAM_INT_SPAN);
    scaled = (28'(vp) <<< PAM_SPAN_SHIFT) / span;
    over_range_indicator  = 1'b0;
    if (scaled > 28'sd2047) begin
      code = PAM_MAX_CODE;
      over_range_indicator  = 1'b1;
    end else if (scaled < -28'sd2048) begin
      code = PAM_MIN_CODE;
      over_range_indicator  = 1'b1;
    end else begin
      code = scaled[11:0] + PAM_MID_CODE;
    end
  end

  // ******************************************************
  // pipeline
  // ******************************************************
  logic [PAM_DATA_W:0] smp_r;
  logic [PAM_DATA_W:0] smp_nxt;
  logic [PAM_DATA_W:0] pipe_q;

  always_comb begin
    smp_nxt = converting ? {over_range_indicator, code} : smp_r;
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      smp_r <= '0;
    end else begin
      smp_r <= smp_nxt;
    end
  end

  // sample register plus LATENCY stages: the edge that samples is not
  // counted, so the result leaves on the fifth edge after it
  pam_delay #(
    .W     (PAM_DATA_W + 1),
    .DEPTH (LATENCY)
  ) u_pipe (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .adv_i    (converting),
    .d_i      (smp_r),
    .q_o      (pipe_q)
  );

  assign sample_data_bus_o = pipe_q[PAM_DATA_W-1:0];
  assign over_range_flag_o = pipe_q[PAM_DATA_W];

  // straight from the pin: no clock may sit in the enable path
  assign sample_data_bus_oe_o = {PAM_DATA_W{~out_en_n_i}};

  // ******************************************************
  // freshness tracking
  // ******************************************************
  logic [3:0] fill_r;
  logic [3:0] fill_nxt;
  logic [2:0] cfg_r;
  logic [2:0] cfg_nxt;
  logic       cfg_chg;

  always_comb begin
    cfg_nxt = pin_s2_r;
    cfg_chg = (cfg_r != pin_s2_r);
    if (!converting || cfg_chg) begin
      fill_nxt = '0;
    end else if (fill_r < 4'(LATENCY)) begin
      fill_nxt = fill_r + 4'h1;
    end else begin
      fill_nxt = fill_r;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fill_r <= '0;
      cfg_r  <= '0;
    end else begin
      fill_r <= fill_nxt;
      cfg_r  <= cfg_nxt;
    end
  end

  assign sample_valid_o = (fill_r == 4'(LATENCY)) && converting;

  // ******************************************************
  // register slave and interrupts
  // ******************************************************
  logic                ack_r;
  logic                ack_nxt;
  logic [31:0]         rd_r;
  logic [31:0]         rd_nxt;
  logic [PAM_EV_W-1:0] sts_r;
  logic [PAM_EV_W-1:0] sts_nxt;
  logic [PAM_EV_W-1:0] msk_r;
  logic [PAM_EV_W-1:0] msk_nxt;
  logic                ctl_r;
  logic                ctl_nxt;
  logic [PAM_EV_W-1:0] ev;
  logic                down_q_r;
  logic                wr_go;
  logic                rd_go;

  assign rd_go = avs_read  && !ack_r;
  assign wr_go = avs_write && ack_r;

  always_comb begin
    ack_nxt = (avs_read || avs_write) && !ack_r;
    ev = '0;
    ev[PAM_EV_OVR]   = over_range_flag_o && converting;
    ev[PAM_EV_FAULT] = mode_fault_o;
    ev[PAM_EV_DOWN]  = (mode == PAM_MODE_DOWN) && !down_q_r;
    msk_nxt = msk_r;
    ctl_nxt = ctl_r;
    sts_nxt = sts_r;
    if (wr_go && avs_byteenable[0]) begin
      case (avs_address)
        PAM_OFS_STATUS: sts_nxt = sts_r & ~avs_writedata[PAM_EV_W-1:0];
        PAM_OFS_MASK:   msk_nxt = avs_writedata[PAM_EV_W-1:0];
        PAM_OFS_CTRL:   ctl_nxt = avs_writedata[PAM_CTRL_EVEN];
        default:        ;
      endcase
    end
    // a new event beats a clear in the same cycle
    if (ctl_r) begin
      sts_nxt = sts_nxt | ev;
    end
    rd_nxt = rd_r;
    if (rd_go) begin
      rd_nxt = 32'h0;
      case (avs_address)
        PAM_OFS_STATUS: rd_nxt[PAM_EV_W-1:0] = sts_r;
        PAM_OFS_MASK:   rd_nxt[PAM_EV_W-1:0] = msk_r;
        PAM_OFS_CTRL:   rd_nxt[PAM_CTRL_EVEN] = ctl_r;
        PAM_OFS_STATE: begin
          rd_nxt[PAM_ST_DATA_LSB +: PAM_DATA_W] = sample_data_bus_o;
          rd_nxt[PAM_ST_OVR]    = over_range_flag_o;
          rd_nxt[PAM_ST_VALID]  = sample_valid_o;
          rd_nxt[PAM_ST_REFEXT] = ref_ext;
          rd_nxt[PAM_ST_MODE_LSB +: 2] = mode;
        end
        default:        rd_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_r    <= 1'b0;
      rd_r     <= '0;
      sts_r    <= '0;
      msk_r    <= PAM_MASK_RST;
      ctl_r    <= PAM_CTRL_RST;
      down_q_r <= 1'b1;
    end else begin
      ack_r    <= ack_nxt;
      rd_r     <= rd_nxt;
      sts_r    <= sts_nxt;
      msk_r    <= msk_nxt;
      ctl_r    <= ctl_nxt;
      down_q_r <= (mode == PAM_MODE_DOWN);
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign avs_readdata    = rd_r;
  assign irq_o           = |(sts_r & msk_r);
endmodule

// ==== src/pam_delay.sv ====
`timescale 1ns/10ps
module pam_delay #(
  parameter int W     = 13,
  parameter int DEPTH = 5
) (
  input  wire logic         mclk_i,   // sample clock
  input  wire logic         arst_n_i, // async reset, low
  input  wire logic         adv_i,    // advance the pipe
  input  wire logic [W-1:0] d_i,      // stage input
  output logic      [W-1:0] q_o       // last stage
);
  logic [W-1:0] stg_r   [DEPTH];
  logic [W-1:0] stg_nxt [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_stage
      always_comb begin
        if (!adv_i) begin
          stg_nxt[g] = stg_r[g];
        end else if (g == 0) begin
          stg_nxt[g] = d_i;
        end else begin
          stg_nxt[g] = stg_r[(g == 0) ? 0 : g-1];
        end
      end

      always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          stg_r[g] <= '0;
        end else begin
          stg_r[g] <= stg_nxt[g];
        end
      end
    end
  endgenerate

  assign q_o = stg_r[DEPTH-1];
endmodule

// ==== src/pam_pkg.sv ====
package pam_pkg;
  // ******************************************************
  // sample path
  // ******************************************************
  localparam int          PAM_DATA_W      = 12;
  localparam int          PAM_AIN_W       = 14;
  localparam int          PAM_LATENCY     = 5;
  localparam logic [11:0] PAM_MID_CODE    = 12'h800;
  localparam logic [11:0] PAM_MAX_CODE    = 12'hfff;
  localparam logic [11:0] PAM_MIN_CODE    = 12'h000;
  localparam logic [11:0] PAM_INT_SPAN    = 12'h800;
  localparam int          PAM_SPAN_SHIFT  = 11;
  localparam real         PAM_FCLK_MAX_MHZ = 15.0;

  // ******************************************************
  // config pin codes {high, low}
  // ******************************************************
  localparam logic [1:0]  PAM_CFG_DOWN    = 2'h0;
  localparam logic [1:0]  PAM_CFG_UNITY   = 2'h1;
  localparam logic [1:0]  PAM_CFG_HALF    = 2'h2;
  localparam logic [1:0]  PAM_CFG_UNUSED  = 2'h3;

  typedef enum logic [1:0] {
    PAM_MODE_DOWN,
    PAM_MODE_UNITY,
    PAM_MODE_HALF,
    PAM_MODE_FAULT
  } pam_mode_t;

  // ******************************************************
  // register map (byte addresses, word aligned)
  // ******************************************************
  localparam int          PAM_ADDR_W      = 4;
  localparam logic [3:0]  PAM_OFS_STATUS  = 4'h0;
  localparam logic [3:0]  PAM_OFS_MASK    = 4'h4;
  localparam logic [3:0]  PAM_OFS_CTRL    = 4'h8;
  localparam logic [3:0]  PAM_OFS_STATE   = 4'hc;
  localparam int          PAM_EV_W        = 3;
  localparam int          PAM_EV_OVR      = 0;
  localparam int          PAM_EV_FAULT    = 1;
  localparam int          PAM_EV_DOWN     = 2;
  localparam int          PAM_CTRL_EVEN   = 0;
  localparam logic [2:0]  PAM_MASK_RST    = 3'h0;
  localparam logic        PAM_CTRL_RST    = 1'b1;
  localparam int          PAM_ST_DATA_LSB = 0;
  localparam int          PAM_ST_OVR      = 12;
  localparam int          PAM_ST_VALID    = 13;
  localparam int          PAM_ST_REFEXT   = 14;
  localparam int          PAM_ST_MODE_LSB = 16;
endpackage

// ==== verif/pam_capture.sv ====
`timescale 1ns/10ps
module pam_capture (
  input  wire logic        mclk_i,  // clk
  input  wire logic [11:0] bus_i,   // data pins
  input  wire logic [11:0] oe_i,    // drive
  input  wire logic        valid_i, // fresh
  output logic      [11:0] word_o,  // latched word
  output logic      [11:0] wire_o   // bus level
);
  // ********************
  // capture latch
  // ********************
  logic [11:0] last_r = 12'h000;
  initial word_o = 12'h000;
  // released bits flip each cycle so a stale value cannot pass as data
  assign wire_o = (bus_i & oe_i) | (~last_r & ~oe_i);
  always @(posedge mclk_i) begin
    last_r <= wire_o;
    if (valid_i && &oe_i) word_o <= wire_o;
  end
endmodule

// ==== verif/pam_core_asserts.sv ====
`timescale 1ns/10ps
module pam_core_asserts
  import pam_pkg::*;
(
  input wire logic               mclk_i,     // clk
  input wire logic               arst_n_i,   // rst
  input wire logic signed [13:0] ain_i,      // in
  input wire logic [11:0]        ext_span_i, // span
  input wire logic               reference_source_select_i, // strap
  input wire logic               config_select_low_i,       // pin
  input wire logic               config_select_high_i,      // pin
  input wire logic               out_en_n_i,           // oe low
  input wire logic [11:0]        sample_data_bus_o,    // data
  input wire logic [11:0]        sample_data_bus_oe_o, // drive
  input wire logic               over_range_flag_o,    // ovr
  input wire logic               sample_valid_o,       // fresh
  input wire logic               mode_fault_o          // fault
);
  // ********************
  // sample path checks
  // ********************
  logic [1:0] cfg;
  logic [3:0] up_r;
  assign cfg = {config_select_high_i, config_select_low_i};
  // pins pass a two-stage synchroniser: ignore them until it has filled
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      up_r <= 4'h0;
    end else if (up_r != 4'hf) begin
      up_r <= up_r + 4'h1;
    end
  end
  // {over-range, code}; the bench keeps ext span at 0x400, so gain doubles
  function automatic logic [12:0] cv(logic signed [15:0] v);
    if (v > 16'sd2047) return 13'h1fff;
    if (v < -16'sd2048) return 13'h1000;
    return {1'b0, v[11:0] ^ 12'h800};
  endfunction
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  sequence run(logic [1:0] c, logic s);
    (up_r > 4'h2 && cfg == c && reference_source_select_i == s &&
     ext_span_i == 12'h400)[*8];
  endsequence
  // result of the sample taken six sampling points back, one cycle on
  a_unity_code: assert property (run(2'h1, 1'b0) |=>
    {over_range_flag_o, sample_data_bus_o} == cv($past(ain_i, 6)))
    else $error("unity code mismatch");
  a_ovr_align: assert property (run(2'h1, 1'b0) |=>
    over_range_flag_o == ($past(ain_i, 6) > 14'sd2047 ||
                          $past(ain_i, 6) < -14'sd2048))
    else $error("over-range not aligned");
  a_half_code: assert property (run(2'h2, 1'b0) |=>
    {over_range_flag_o, sample_data_bus_o} == cv($past(ain_i, 6) >>> 1))
    else $error("half gain code mismatch");
  a_ext_code: assert property (run(2'h1, 1'b1) |=>
    {over_range_flag_o, sample_data_bus_o} == cv(16'sd2 * $past(ain_i, 6)))
    else $error("external span code mismatch");
  a_fault_flag: assert property ((up_r > 4'h2 && cfg == 2'h3)[*3] |->
    mode_fault_o) else $error("unused mode not flagged");
  a_down_freeze: assert property ((up_r > 4'h2 && cfg == 2'h0)[*8] |=>
    $stable(sample_data_bus_o)) else $error("data moved in power-down");
  a_down_idle: assert property ((up_r > 4'h2 && cfg == 2'h0)[*3] |->
    !sample_valid_o) else $error("valid in power-down");
  a_oe_drive: assert property (!out_en_n_i |->
    sample_data_bus_oe_o == 12'hfff) else $error("bus not driven");
  a_oe_release: assert property (out_en_n_i |->
    sample_data_bus_oe_o == 12'h000) else $error("bus not released");
  c_unity: cover property (run(2'h1, 1'b0));
  c_half: cover property (run(2'h2, 1'b0));
  c_down: cover property ((cfg == 2'h0)[*8]);
endmodule

bind pam_core pam_core_asserts i_pam_core_asserts (
  .mclk_i, .arst_n_i, .ain_i, .ext_span_i, .reference_source_select_i,
  .config_select_low_i, .config_select_high_i, .out_en_n_i,
  .sample_data_bus_o, .sample_data_bus_oe_o, .over_range_flag_o,
  .sample_valid_o, .mode_fault_o);

// ==== verif/tb_pam_core.sv ====
`timescale 1ns/10ps
module tb_pam_core;
  import pam_pkg::*;
  // ********************
  // stimulus and checks
  // ********************
  logic               mclk_i   = 1'b0;
  logic               arst_n_i = 1'b0;
  logic signed [13:0] ain_i    = '0;
  logic [1:0]         cfg      = 2'h1;
  logic               ref_sel  = 1'b0;
  logic               oe_n     = 1'b0;
  logic [3:0]         addr     = '0;
  logic               rd_en    = 1'b0;
  logic               wr_en    = 1'b0;
  logic [31:0]        wdat     = '0;
  logic [31:0]        rdat, r;
  logic [11:0]        dat, oe, cap, lvl, held;
  logic               over_range_indicator, vld, flt, wrq, irq;
  int                 fail_count = 0;
  int                 tests_run  = 0;

  always #2.5 mclk_i = ~mclk_i;

  pam_core i_pam_core (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .ain_i(ain_i),
    .ext_span_i(12'h400), .reference_source_select_i(ref_sel),
    .config_select_low_i(cfg[0]), .config_select_high_i(cfg[1]),
    .out_en_n_i(oe_n), .sample_data_bus_o(dat), .sample_data_bus_oe_o(oe),
    .over_range_flag_o(over_range_indicator), .sample_valid_o(vld), .mode_fault_o(flt),
    .avs_address(addr), .avs_read(rd_en), .avs_write(wr_en),
    .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat),
    .avs_waitrequest(wrq), .irq_o(irq));
  pam_capture i_pam_capture (.mclk_i(mclk_i), .bus_i(dat), .oe_i(oe),
    .valid_i(vld), .word_o(cap), .wire_o(lvl));

  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // request stays put until waitrequest is seen low at a rising edge
  task automatic acc(logic w, logic [3:0] a, logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wdat <= d;
    wr_en <= w;
    rd_en <= !w;
    do begin
      @(posedge mclk_i);
      n++;
    end while (wrq !== 1'b0 && n < 40);
    if (wrq !== 1'b0) begin
      fail_count++;
      $display("[FAIL] %0t bus access timed out", $time);
      wrap_up;
    end
    r = rdat;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic pins(logic [1:0] c, logic s);
    cfg <= c;
    ref_sel <= s;
    ain_i <= '0;
    repeat (12) @(posedge mclk_i);
  endtask

  // one sample amid zeros: old code up to the fifth edge, new one after it
  task automatic lat(logic signed [13:0] v, logic [12:0] e);
    ain_i <= v;
    @(posedge mclk_i);
    ain_i <= '0;
    repeat (5) @(posedge mclk_i);
    chk(dat === 12'h800, "result too early");
    @(posedge mclk_i);
    chk({over_range_indicator, dat} === e, "result code");
    @(posedge mclk_i);
    chk(cap === e[11:0], "captured word");
  endtask

  initial begin
    repeat (16) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    @(posedge mclk_i);
    acc(0, PAM_OFS_MASK, '0);
    chk(r[2:0] === PAM_MASK_RST, "mask reset");
    acc(0, PAM_OFS_CTRL, '0);
    chk(r[0] === PAM_CTRL_RST, "ctrl reset");
    acc(0, 4'h2, '0);
    chk(r === 32'h0, "unmapped read");
    pins(2'h1, 1'b0);
    lat(14'sd1000, 13'h0be8);
    lat(-14'sd1, 13'h07ff);
    lat(14'sd2047, 13'h0fff);
    lat(14'sd2048, 13'h1fff);
    lat(-14'sd2048, 13'h0000);
    lat(-14'sd2049, 13'h1000);
    pins(2'h1, 1'b1);
    lat(14'sd1000, 13'h0fd0);
    lat(14'sd1024, 13'h1fff);
    pins(2'h2, 1'b0);
    lat(14'sd3000, 13'h0ddc);
    lat(-14'sd4096, 13'h0000);
    lat(14'sd4098, 13'h1fff);
    pins(2'h3, 1'b0);
    held = dat;
    chk(flt === 1'b1 && irq === 1'b0, "fault while masked");
    ain_i <= 14'sd500;
    repeat (8) @(posedge mclk_i);
    chk(dat === held, "unused mode converted");
    acc(0, PAM_OFS_STATE, '0);
    chk(r[17:16] === 2'h3, "state mode");
    acc(1, PAM_OFS_MASK, 32'h2);
    chk(irq === 1'b1, "irq unmasked");
    oe_n <= 1'b1;
    #1 chk(oe === 12'h000 && lvl === ~dat, "bus released");
    @(posedge mclk_i);
    oe_n <= 1'b0;
    #1 chk(oe === 12'hfff, "bus driven");
    @(posedge mclk_i);
    pins(2'h1, 1'b0);
    acc(1, PAM_OFS_STATUS, 32'h2);
    acc(0, PAM_OFS_STATUS, '0);
    chk(irq === 1'b0 && r[PAM_EV_FAULT] === 1'b0, "fault cleared");
    pins(2'h0, 1'b0);
    held = dat;
    ain_i <= 14'sd1000;
    repeat (8) @(posedge mclk_i);
    chk(vld === 1'b0 && dat === held, "powered down");
    acc(0, PAM_OFS_STATUS, '0);
    chk(r[PAM_EV_DOWN] === 1'b1, "down event");
    pins(2'h1, 1'b0);
    chk(vld === 1'b1, "fresh again");
    lat(14'sd1000, 13'h0be8);
    wrap_up;
  end
endmodule
